// File: core/ptoc_regs.sv
// register bank for telemetry readback and output control
// Functional notes
// - input voltage reads 10-bit code, 25mV steps
// - output voltage reads 13-bit code, 1.25mV steps
// - output current reads 14-bit code, 62.5mA steps
// - current compared to fault and warning limits
// - sensed temperature drives over-temperature detection
// - temperature two's complement, bit 9 sign
// - sign clear all ones +511; 1..01 -511
// - revision fetched by single-byte read
// - revision upper nibble always 0011
// - revision lower nibble always 0011
// - compensation bit 4 selects 20/50 pF
// - compensation bits 3:1 ramp code, reset 110
// - compensation bit 0 disables slave fault detect
// - compensation register resets to 0x0D
// - bit 6 enables active discharge at turn-off
// - bits 5:2 set power-good release delay
// - bits 1:0 select feedback divider
`timescale 1ns/10ps
module ptoc_regs
  import ptoc_pkg::*;
#(
  parameter int MS_CYCLES = PTOC_MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ptoc_cmd_t cmd_i,
  input wire ptoc_meas_t meas_i,
  input wire logic [PTOC_IOUT_W-1:0] overcurrent_fault_threshold_i,
  input wire logic [PTOC_IOUT_W-1:0] overcurrent_warning_threshold_i,
  input wire logic [PTOC_TEMP_W-1:0] ot_fault_limit_i,
  input wire logic [PTOC_TEMP_W-1:0] ot_warn_limit_i,
  input wire logic soft_start_done_i,
  input wire logic output_off_req_i,
  output ptoc_rsp_t rsp_o,
  output logic oc_fault_o,
  output logic oc_warn_o,
  output logic ot_fault_o,
  output logic ot_warn_o,
  output logic feedforward_cap_select_o,
  output logic [2:0] ramp_code_o,
  output logic slave_fault_detect_en_o,
  output logic output_discharge_o,
  output logic power_good_pin_o,
  output logic [1:0] feedback_divider_select_o
);

  localparam logic [PTOC_MSCNT_W-1:0] MS_LAST = PTOC_MSCNT_W'(MS_CYCLES - 1);

  ptoc_state_t st;
  ptoc_state_t next_st;

  // zero-extend a field into the 16-bit answer word, upper bits read zero
  function automatic logic [15:0] ptoc_ext(input logic [15:0] v, input int w);
    logic [15:0] m;
    m = 16'hFFFF >> (16 - w);
    return v & m;
  endfunction : ptoc_ext

  // read decode: value and answer length for a command code
  function automatic logic [17:0] ptoc_read(input ptoc_state_t s, input logic [7:0] c);
    logic [17:0] r;
    r = {PTOC_LEN_NONE, 16'h0000};
    case (c)
      PTOC_CMD_VIN: r = {PTOC_LEN_WORD, ptoc_ext(16'(s.vin), PTOC_VIN_W)};
      PTOC_CMD_VOUT: r = {PTOC_LEN_WORD, ptoc_ext(16'(s.vout), PTOC_VOUT_W)};
      PTOC_CMD_IOUT: r = {PTOC_LEN_WORD, ptoc_ext(16'(s.iout), PTOC_IOUT_W)};
      PTOC_CMD_TEMP: r = {PTOC_LEN_WORD, ptoc_ext(16'(s.temp), PTOC_TEMP_W)};
      PTOC_CMD_REV: r = {PTOC_LEN_BYTE, 8'h00, PTOC_REV_VALUE};
      PTOC_CMD_COMP: r = {PTOC_LEN_BYTE, 8'h00, s.comp};
      PTOC_CMD_OUTCTL: r = {PTOC_LEN_BYTE, 8'h00, s.outctl};
      default: r = {PTOC_LEN_NONE, 16'h0000};
    endcase
    return r;
  endfunction : ptoc_read

  // next-state logic for the whole bank
  always_comb begin
    logic [17:0] rd;
    logic [4:0] pg_target;
    next_st = st;
    rd = ptoc_read(st, cmd_i.code);
    pg_target = PTOC_PGD_BASE + PTOC_PGD_STEP * {1'b0, st.outctl[PTOC_OUT_PGD_HI:PTOC_OUT_PGD_LO]};

    // answers last one cycle; writes are acknowledged with no data
    next_st.rsp = '0;
    if (cmd_i.valid) begin
      next_st.rsp.valid = 1'b1;
      if (cmd_i.write) begin
        // voltage, current and revision take no writes; answer them as unsupported
        case (cmd_i.code)
          PTOC_CMD_COMP: next_st.comp = cmd_i.data[7:0];
          PTOC_CMD_OUTCTL: next_st.outctl = cmd_i.data[7:0];
          PTOC_CMD_TEMP: next_st.temp = cmd_i.data[PTOC_TEMP_W-1:0];
          default: next_st.rsp.unsupported = 1'b1;
        endcase
      end else begin
        next_st.rsp.len = rd[17:16];
        next_st.rsp.data = rd[15:0];
        next_st.rsp.unsupported = (rd[17:16] == PTOC_LEN_NONE);
      end
    end

    // a fresh measurement set replaces any stored readings
    if (meas_i.valid) begin
      next_st.vin = meas_i.vin;
      next_st.vout = meas_i.vout;
      next_st.iout = meas_i.iout;
      next_st.temp = meas_i.temp;
    end

    // limit checks track the stored readings, so a host write to the
    // temperature is seen by the over-temperature check as well
    next_st.oc_fault = (st.iout >= overcurrent_fault_threshold_i);
    next_st.oc_warn = (st.iout >= overcurrent_warning_threshold_i);
    next_st.ot_fault = ($signed(st.temp) >= $signed(ot_fault_limit_i));
    next_st.ot_warn = ($signed(st.temp) >= $signed(ot_warn_limit_i));

    // active discharge only while turned off and enabled
    next_st.discharge = output_off_req_i & st.outctl[PTOC_OUT_DISCH];

    // power-good release after soft-start plus the programmed delay
    next_st.ms_cnt = '0;
    case (st.pg_state)
      PTOC_PG_IDLE: begin
        next_st.pg_high = 1'b0;
        next_st.pg_ms = '0;
        if (soft_start_done_i && !output_off_req_i) begin
          next_st.pg_state = PTOC_PG_WAIT;
        end
      end
      PTOC_PG_WAIT: begin
        // ms tick from a divider; the delay code is read live
        next_st.ms_cnt = (st.ms_cnt == MS_LAST) ? '0 : st.ms_cnt + 1'b1;
        if (st.ms_cnt == MS_LAST) begin
          next_st.pg_ms = st.pg_ms + 5'h01;
        end
        if (output_off_req_i || !soft_start_done_i) begin
          next_st.pg_state = PTOC_PG_IDLE;
        end else if (st.pg_ms >= pg_target) begin
          next_st.pg_state = PTOC_PG_HIGH;
          next_st.pg_high = 1'b1;
        end
      end
      PTOC_PG_HIGH: begin
        if (output_off_req_i || !soft_start_done_i) begin
          next_st.pg_state = PTOC_PG_IDLE;
          next_st.pg_high = 1'b0;
        end
      end
      default: begin
        next_st.pg_state = PTOC_PG_IDLE;
        next_st.pg_high = 1'b0;
      end
    endcase
  end

  // single state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.vin <= PTOC_VIN_RST[PTOC_VIN_W-1:0];
      st.vout <= PTOC_VOUT_RST[PTOC_VOUT_W-1:0];
      st.iout <= PTOC_IOUT_RST[PTOC_IOUT_W-1:0];
      st.temp <= PTOC_TEMP_RST;
      st.comp <= PTOC_COMP_RST;
      st.outctl <= PTOC_OUTCTL_RST;
      st.pg_state <= PTOC_PG_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign rsp_o = st.rsp;
  assign oc_fault_o = st.oc_fault;
  assign oc_warn_o = st.oc_warn;
  assign ot_fault_o = st.ot_fault;
  assign ot_warn_o = st.ot_warn;
  assign feedforward_cap_select_o = st.comp[PTOC_COMP_CFF];
  assign ramp_code_o = st.comp[PTOC_COMP_RAMP_HI:PTOC_COMP_RAMP_LO];
  assign slave_fault_detect_en_o = ~st.comp[PTOC_COMP_SLVDIS];
  assign output_discharge_o = st.discharge;
  assign power_good_pin_o = st.pg_high;
  assign feedback_divider_select_o = st.outctl[PTOC_OUT_DIV_HI:PTOC_OUT_DIV_LO];

endmodule : ptoc_regs

// File: core/ptoc_pkg.sv
// shared constants and types for the telemetry and output control registers
package ptoc_pkg;
  // command codes, which double as register addresses
  localparam logic [7:0] PTOC_CMD_VIN = 8'h88;
  localparam logic [7:0] PTOC_CMD_VOUT = 8'h8B;
  localparam logic [7:0] PTOC_CMD_IOUT = 8'h8C;
  localparam logic [7:0] PTOC_CMD_TEMP = 8'h8D;
  localparam logic [7:0] PTOC_CMD_REV = 8'h98;
  localparam logic [7:0] PTOC_CMD_COMP = 8'hD0;
  localparam logic [7:0] PTOC_CMD_OUTCTL = 8'hD1;
  // field widths and positions
  localparam int PTOC_VIN_W = 10;
  localparam int PTOC_VOUT_W = 13;
  localparam int PTOC_IOUT_W = 14;
  localparam int PTOC_TEMP_W = 10;
  localparam int PTOC_COMP_CFF = 4;
  localparam int PTOC_COMP_RAMP_HI = 3;
  localparam int PTOC_COMP_RAMP_LO = 1;
  localparam int PTOC_COMP_SLVDIS = 0;
  localparam int PTOC_OUT_DISCH = 6;
  localparam int PTOC_OUT_PGD_HI = 5;
  localparam int PTOC_OUT_PGD_LO = 2;
  localparam int PTOC_OUT_DIV_HI = 1;
  localparam int PTOC_OUT_DIV_LO = 0;
  // reset values
  localparam logic [15:0] PTOC_VIN_RST = 16'h0000;
  localparam logic [15:0] PTOC_VOUT_RST = 16'h0000;
  localparam logic [15:0] PTOC_IOUT_RST = 16'h0000;
  localparam logic [PTOC_TEMP_W-1:0] PTOC_TEMP_RST = 10'h032;
  localparam logic [7:0] PTOC_REV_VALUE = 8'h33;
  localparam logic [7:0] PTOC_COMP_RST = 8'h0D;
  localparam logic [7:0] PTOC_OUTCTL_RST = 8'h00;
  // answer lengths in bytes
  localparam logic [1:0] PTOC_LEN_NONE = 2'h0;
  localparam logic [1:0] PTOC_LEN_BYTE = 2'h1;
  localparam logic [1:0] PTOC_LEN_WORD = 2'h2;
  // timing: power-good release base delay and code step, in ms
  localparam int PTOC_CLK_MHZ = 250;
  localparam int PTOC_PGD_BASE_MS = 2;
  localparam int PTOC_PGD_STEP_MS = 1;
  localparam int PTOC_MS_CYCLES = PTOC_CLK_MHZ * 1000;
  localparam int PTOC_MSCNT_W = 18;
  localparam logic [4:0] PTOC_PGD_BASE = 5'(PTOC_PGD_BASE_MS);
  localparam logic [4:0] PTOC_PGD_STEP = 5'(PTOC_PGD_STEP_MS);

  // one register-port command from the transport
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } ptoc_cmd_t;

  // one answer back to the transport
  typedef struct packed {
    logic valid;
    logic unsupported;
    logic [1:0] len;
    logic [15:0] data;
  } ptoc_rsp_t;

  // one set of measurements from the front end
  typedef struct packed {
    logic valid;
    logic [PTOC_VIN_W-1:0] vin;
    logic [PTOC_VOUT_W-1:0] vout;
    logic [PTOC_IOUT_W-1:0] iout;
    logic [PTOC_TEMP_W-1:0] temp;
  } ptoc_meas_t;

  // power-good delay sequencer
  typedef enum logic [1:0] {
    PTOC_PG_IDLE,
    PTOC_PG_WAIT,
    PTOC_PG_HIGH
  } ptoc_pg_state_t;

  // whole state of the register block
  typedef struct packed {
    logic [PTOC_VIN_W-1:0] vin;
    logic [PTOC_VOUT_W-1:0] vout;
    logic [PTOC_IOUT_W-1:0] iout;
    logic [PTOC_TEMP_W-1:0] temp;
    logic [7:0] comp;
    logic [7:0] outctl;
    logic oc_fault;
    logic oc_warn;
    logic ot_fault;
    logic ot_warn;
    ptoc_rsp_t rsp;
    ptoc_pg_state_t pg_state;
    logic [PTOC_MSCNT_W-1:0] ms_cnt;
    logic [4:0] pg_ms;
    logic pg_high;
    logic discharge;
  } ptoc_state_t;
endpackage : ptoc_pkg

// File: tb/ptoc_regs_assertions.sv
// port assertions for the register bank
`timescale 1ns/10ps
module ptoc_regs_assertions
  import ptoc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ptoc_cmd_t cmd_i,
  input wire ptoc_meas_t meas_i,
  input wire logic [PTOC_IOUT_W-1:0] overcurrent_fault_threshold_i,
  input wire logic output_off_req_i,
  input wire ptoc_rsp_t rsp_o,
  input wire logic oc_fault_o,
  input wire logic feedforward_cap_select_o,
  input wire logic [2:0] ramp_code_o,
  input wire logic slave_fault_detect_en_o,
  input wire logic output_discharge_o,
  input wire logic power_good_pin_o,
  input wire logic [1:0] feedback_divider_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // command steps: a write to one code, a lone measurement pulse
  sequence s_wr(c); cmd_i.valid && cmd_i.write && cmd_i.code == c; endsequence
  sequence s_meas; meas_i.valid ##1 !meas_i.valid; endsequence
  property p_one; 1 |=> rsp_o.valid == $past(cmd_i.valid); endproperty
  property p_rev;
    cmd_i.valid && !cmd_i.write && cmd_i.code == PTOC_CMD_REV
      |=> rsp_o.len == PTOC_LEN_BYTE && rsp_o.data == 16'h0033;
  endproperty
  property p_ro;
    cmd_i.valid && cmd_i.write && cmd_i.code inside {8'h88, 8'h8B, 8'h8C, 8'h98}
      |=> rsp_o.unsupported;
  endproperty
  property p_comp;
    s_wr(PTOC_CMD_COMP) |=> {feedforward_cap_select_o, ramp_code_o,
      !slave_fault_detect_en_o} == $past(cmd_i.data[4:0]);
  endproperty
  property p_div;
    s_wr(PTOC_CMD_OUTCTL) |=> feedback_divider_select_o == $past(cmd_i.data[1:0]);
  endproperty
  // threshold held steady by the source across the compare
  property p_oc;
    s_meas |=> oc_fault_o == ($past(meas_i.iout, 2) >= $past(overcurrent_fault_threshold_i));
  endproperty
  property p_disch; !output_off_req_i |=> !output_discharge_o; endproperty
  property p_pgoff; output_off_req_i |=> !power_good_pin_o; endproperty
  a_one: assert property (p_one) else $error("answer timing wrong");
  a_rev: assert property (p_rev) else $error("revision byte wrong");
  a_ro: assert property (p_ro) else $error("read-only write taken");
  a_comp: assert property (p_comp) else $error("compensation fields wrong");
  a_div: assert property (p_div) else $error("divider select wrong");
  a_oc: assert property (p_oc) else $error("overcurrent flag wrong");
  a_disch: assert property (p_disch) else $error("discharge while on");
  a_pgoff: assert property (p_pgoff) else $error("power good kept when off");
endmodule : ptoc_regs_assertions

// File: tb/ptoc_host.sv
// host model issuing register commands and collecting answers
`timescale 1ns/10ps
module ptoc_host
  import ptoc_pkg::*;
(
  input wire logic clk_i,
  input wire ptoc_rsp_t rsp_i,
  output ptoc_cmd_t cmd_o
);
  initial cmd_o = '0;
  // one command per call, answer read once it has settled
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                      output ptoc_rsp_t r);
    @(posedge clk_i);
    cmd_o <= '{1'b1, wr, c, d};
    @(posedge clk_i);
    cmd_o <= '0;
    #1 r = rsp_i;
  endtask : xfer
endmodule : ptoc_host

// File: tb/test_ptoc_regs.sv
// self-checking bench for the telemetry and output control registers
`timescale 1ns/10ps
module test_ptoc_regs;
  import ptoc_pkg::*;
  localparam int MSC = 10;
  logic clk_i, rst_i, ssd = 1'b0, off = 1'b0;
  ptoc_cmd_t cmd;
  ptoc_meas_t meas = '0;
  ptoc_rsp_t rsp, r;
  logic [13:0] ocf = '0, ocw = '0;
  logic [9:0] otf = '0, otw = '0, t;
  logic cff, sfd, dis, pg, ocf_o, ocw_o, otf_o, otw_o;
  logic [2:0] ramp;
  logic [1:0] div;
  logic [31:0] seed = 32'h84DCF3CC, v, w;
  int n_mismatch = 0, comparisons = 0, k, n;
  logic [7:0] cd [7] = '{8'h88, 8'h8B, 8'h8C, 8'h8D, 8'h98, 8'hD0, 8'hD1};
  logic [15:0] rv [7] = '{16'h0, 16'h0, 16'h0, 16'h32, 16'h33, 16'hD, 16'h0};
  ptoc_host host (.clk_i, .rsp_i(rsp), .cmd_o(cmd));
  ptoc_regs #(.MS_CYCLES(MSC)) dut (.clk_i, .rst_i, .cmd_i(cmd), .meas_i(meas),
    .overcurrent_fault_threshold_i(ocf), .overcurrent_warning_threshold_i(ocw),
    .ot_fault_limit_i(otf), .ot_warn_limit_i(otw), .soft_start_done_i(ssd),
    .output_off_req_i(off), .rsp_o(rsp), .oc_fault_o(ocf_o), .oc_warn_o(ocw_o),
    .ot_fault_o(otf_o), .ot_warn_o(otw_o), .feedforward_cap_select_o(cff),
    .ramp_code_o(ramp), .slave_fault_detect_en_o(sfd), .output_discharge_o(dis),
    .power_good_pin_o(pg), .feedback_divider_select_o(div));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [1:0] l, input logic [15:0] e);
    host.xfer(1'b0, c, 16'h0, r);
    chk({r.unsupported, r.len}, {l == 2'h0, l});
    chk(r.data, e);
  endtask : rd
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    // set in the process so the async reset sees a rising edge at time zero
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // writes to read-only places first, then every reset value
    for (k = 0; k < 5; k++) if (k != 3) begin
      host.xfer(1'b1, cd[k], 16'hFFFF, r);
      chk(r.unsupported, 1'b1);
    end
    for (k = 0; k < 7; k++) rd(cd[k], k < 4 ? 2'h2 : 2'h1, rv[k]);
    rd(8'h55, 2'h0, 16'h0);
    // temperature override: only bits 9:0 are stored, the rest read zero
    host.xfer(1'b1, 8'h8D, 16'hFFFF, r);
    chk(r.unsupported, 1'b0);
    rd(8'h8D, 2'h2, 16'h03FF);
    $display("test reset done");
    v = rnd();
    host.xfer(1'b1, 8'hD0, {8'h0, v[7:0]}, r);
    chk({cff, ramp, !sfd}, v[4:0]);
    rd(8'hD0, 2'h1, {8'h0, v[7:0]});
    for (k = 0; k < 4; k++) begin
      host.xfer(1'b1, 8'hD1, {9'h0, k[0], 4'h0, k[1:0]}, r);
      chk(div, k[1:0]);
      @(posedge clk_i);
      off <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk(dis, k[0]);
      off <= 1'b0;
    end
    $display("test control done");
    for (k = 0; k < 6; k++) begin
      v = rnd();
      w = rnd();
      t = k == 0 ? 10'h1FF : k == 1 ? 10'h201 : w[23:14];
      @(posedge clk_i);
      meas <= '{1'b1, v[9:0], v[22:10], w[13:0], t};
      ocf <= v[31:18];
      ocw <= w[31:18];
      otf <= v[31:22];
      @(posedge clk_i);
      meas.valid <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk({ocf_o, ocw_o}, {w[13:0] >= v[31:18], w[13:0] >= w[31:18]});
      chk({otf_o, otw_o}, {$signed(t) >= $signed(v[31:22]), !t[9]});
      rd(8'h88, 2'h2, {6'h0, v[9:0]});
      rd(8'h8B, 2'h2, {3'h0, v[22:10]});
      rd(8'h8C, 2'h2, {2'h0, w[13:0]});
      rd(8'h8D, 2'h2, {6'h0, t});
    end
    $display("test telemetry done");
    for (k = 0; k < 2; k++) begin
      host.xfer(1'b1, 8'hD1, {10'h0, k[3:0], 2'h0}, r);
      @(posedge clk_i);
      ssd <= 1'b1;
      n = 0;
      while (pg !== 1'b1 && n < 100) begin
        // look after the edge so the freshly launched pin value has settled
        @(posedge clk_i);
        #1;
        n++;
      end
      chk(n >= (2 + k) * MSC && n <= (2 + k) * MSC + 3, 1'b1);
      if (n == 100) conclude();
      off <= 1'b1;
      @(posedge clk_i);
      ssd <= 1'b0;
      off <= 1'b0;
      @(posedge clk_i);
    end
    $display("test power good done");
    conclude();
  end
endmodule : test_ptoc_regs
bind ptoc_regs ptoc_regs_assertions u_chk (.clk_i, .rst_i, .cmd_i, .meas_i,
  .overcurrent_fault_threshold_i, .output_off_req_i, .rsp_o, .oc_fault_o,
  .feedforward_cap_select_o, .ramp_code_o, .slave_fault_detect_en_o,
  .output_discharge_o, .power_good_pin_o, .feedback_divider_select_o);
